// ### common/fcps_cfg.svh
`ifndef FCPS_CFG_SVH
`define FCPS_CFG_SVH
// Command addresses and data, word mode.
`define FCPS_ADDR_UNLOCK1   22'h000555
`define FCPS_ADDR_UNLOCK2   22'h0002aa
`define FCPS_DATA_UNLOCK1   16'h00aa
`define FCPS_DATA_UNLOCK2   16'h0055
`define FCPS_DATA_PROGRAM   16'h00a0
`define FCPS_DATA_ERASE     16'h0080
`define FCPS_DATA_SECTOR    16'h0030
`define FCPS_DATA_CHIP      16'h0010
`define FCPS_DATA_ERASED    8'hff
// Status bit positions.
`define FCPS_BIT_POLL       7
`define FCPS_BIT_TIMEOUT    5
// Timing: clock period and bus figures in ns, sector erase window in us.
`define FCPS_CLK_NS         4
`define FCPS_WR_PULSE_NS    35
`define FCPS_WR_HIGH_NS     20
`define FCPS_RD_ACCESS_NS   70
`define FCPS_RD_HIGH_NS     20
`define FCPS_RST_PULSE_NS   500
`define FCPS_RST_HIGH_NS    200
`define FCPS_TOW_US         50
`define FCPS_WR_PULSE_CYC   ((`FCPS_WR_PULSE_NS + `FCPS_CLK_NS - 1) / `FCPS_CLK_NS)
`define FCPS_WR_HIGH_CYC    ((`FCPS_WR_HIGH_NS + `FCPS_CLK_NS - 1) / `FCPS_CLK_NS)
`define FCPS_RD_ACCESS_CYC  ((`FCPS_RD_ACCESS_NS + `FCPS_CLK_NS - 1) / `FCPS_CLK_NS + 1)
`define FCPS_RD_HIGH_CYC    ((`FCPS_RD_HIGH_NS + `FCPS_CLK_NS - 1) / `FCPS_CLK_NS)
`define FCPS_RST_PULSE_CYC  ((`FCPS_RST_PULSE_NS + `FCPS_CLK_NS - 1) / `FCPS_CLK_NS)
`define FCPS_RST_HIGH_CYC   ((`FCPS_RST_HIGH_NS + `FCPS_CLK_NS - 1) / `FCPS_CLK_NS)
`define FCPS_TOW_CYC        ((`FCPS_TOW_US * 1000 + `FCPS_CLK_NS - 1) / `FCPS_CLK_NS)
`endif

// ### common/fcps_pkg.sv
package fcps_pkg;
   typedef enum logic [1:0] {
      FCPS_OP_PROGRAM = 2'h0,
      FCPS_OP_SECTOR  = 2'h1,
      FCPS_OP_CHIP    = 2'h2,
      FCPS_OP_RESET   = 2'h3
   } fcps_op_e;
   typedef enum logic [8:0] {
      FCPS_IDLE  = 9'h001,
      FCPS_RSTLO = 9'h002,
      FCPS_RSTHI = 9'h004,
      FCPS_WLO   = 9'h008,
      FCPS_WHI   = 9'h010,
      FCPS_RLO   = 9'h020,
      FCPS_RHI   = 9'h040,
      FCPS_EVAL  = 9'h080,
      FCPS_DONE  = 9'h100
   } fcps_state_e;
   typedef logic [21:0] fcps_addr_t;
   typedef logic [15:0] fcps_data_t;
endpackage

// ### dv/fcps_flash_model.sv
`include "fcps_cfg.svh"

module fcps_flash_model #(
   parameter int PROG_CYC  = 40,
   parameter int TOW_CYC   = 40,
   parameter int ERASE_CYC = 60
) (
   // Clock and test control.
   input  wire logic                 clock,
   input  wire logic                 fail_mode,
   // Flash pins.
   input  wire fcps_pkg::fcps_addr_t addr,
   input  wire logic                 ce_n,
   input  wire logic                 oe_n,
   input  wire logic                 we_n,
   input  wire logic                 reset_n,
   input  wire fcps_pkg::fcps_data_t dq_wr,
   output fcps_pkg::fcps_data_t      dq_rd,
   output logic                      ready_busy_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import fcps_pkg::*;
   fcps_data_t mem [256];
   fcps_data_t last_q = 16'h0000;
   fcps_data_t pgm_dat_q = 16'h0000;
   fcps_addr_t wa_q = 22'h000000;
   int         step_q = 0, busy_q = 0, n_sect = 0, n_chip = 0, rst_lo = 0, rst_len = 0;
   logic       tog_q = 0, pgm_q = 0, stuck_q = 0, we_p = 1, oe_p = 1;
   wire        at_u1   = wa_q == `FCPS_ADDR_UNLOCK1;
   wire        u1      = at_u1 && dq_wr == `FCPS_DATA_UNLOCK1;
   wire        u2      = wa_q == `FCPS_ADDR_UNLOCK2 && dq_wr == `FCPS_DATA_UNLOCK2;
   wire        we_rise = !we_p && we_n && !ce_n;
   wire        win     = busy_q > ERASE_CYC && !pgm_q;
   wire fcps_data_t status = {8'h00, pgm_q ? ~pgm_dat_q[7] : 1'b0, tog_q, stuck_q, 5'h00};
   // A released bus shows the inverse of its last value, so stale data never matches.
   assign dq_rd = (ce_n || oe_n) ? ~last_q : (busy_q != 0) ? status : mem[addr[7:0]];
   assign ready_busy_out = busy_q == 0;
   initial foreach (mem[i]) mem[i] = 16'hffff;
   always @(posedge clock) begin
      we_p <= we_n;
      oe_p <= oe_n;
      // Address is latched as the write strobe falls, data as it rises.
      if (we_p && !we_n && !ce_n) wa_q <= addr;
      if (!ce_n && !oe_n) last_q <= dq_rd;
      if (!reset_n) begin
         rst_lo <= rst_lo + 1;
         step_q <= 0;
         busy_q <= 0;
         stuck_q <= 0;
      end else begin
         if (rst_lo != 0) rst_len <= rst_lo;
         rst_lo <= 0;
         if (!oe_n && oe_p && !ce_n && busy_q != 0) tog_q <= ~tog_q;
         // A stuck operation does not end until reset or until fail_mode drops, and raises the timeout flag instead.
         if (busy_q == 1 && fail_mode) stuck_q <= 1;
         else if (busy_q != 0) busy_q <= busy_q - 1;
         if (busy_q == 1 && !pgm_q && !fail_mode) foreach (mem[i]) mem[i] <= 16'hffff;
         if (we_rise) begin
            step_q <= 0;
            if (win && dq_wr == `FCPS_DATA_SECTOR) begin
               n_sect <= n_sect + 1;
               busy_q <= TOW_CYC + ERASE_CYC;
            end else case (step_q)
               0, 4: if (u1) step_q <= step_q + 1;
               1, 5: if (u2) step_q <= step_q + 1;
               2: if (at_u1 && dq_wr == `FCPS_DATA_PROGRAM) step_q <= 3;
                  else if (at_u1 && dq_wr == `FCPS_DATA_ERASE) step_q <= 4;
               3: begin
                  mem[wa_q[7:0]] <= dq_wr;
                  pgm_dat_q <= dq_wr;
                  pgm_q <= 1;
                  busy_q <= PROG_CYC;
               end
               6: if (dq_wr == `FCPS_DATA_SECTOR) begin
                  n_sect <= 1;
                  pgm_q <= 0;
                  busy_q <= TOW_CYC + ERASE_CYC;
               end else if (at_u1 && dq_wr == `FCPS_DATA_CHIP) begin
                  n_chip <= n_chip + 1;
                  pgm_q <= 0;
                  busy_q <= ERASE_CYC;
               end
               default: step_q <= 0;
            endcase
         end
      end
   end
endmodule

// ### dv/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import fcps_pkg::*;
   logic       clock, sys_rst, cmd_valid, cmd_more, fail_mode;
   fcps_op_e   cmd_op;
   fcps_addr_t cmd_addr, flash_addr;
   fcps_data_t cmd_data, flash_dq_out, dq_rd, dq_in;
   logic       cmd_ready, done_pulse, done_fail, ce_n, oe_n, we_n, rst_n, dq_oe_n, rdy;
   int         err_total = 0, n_checks = 0;
   assign dq_in = !dq_oe_n ? flash_dq_out : dq_rd;
   fcps_ctrl dut_u (.clock(clock), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
      .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_more(cmd_more), .cmd_ready(cmd_ready),
      .done_pulse(done_pulse), .done_fail(done_fail), .flash_addr(flash_addr),
      .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_reset_n(rst_n),
      .flash_dq_out(flash_dq_out), .flash_dq_oe_n(dq_oe_n), .flash_dq_in(dq_in),
      .ready_busy_out(rdy));
   fcps_flash_model flash_u (.clock(clock), .fail_mode(fail_mode), .addr(flash_addr),
      .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .reset_n(rst_n), .dq_wr(flash_dq_out),
      .dq_rd(dq_rd), .ready_busy_out(rdy));
   initial begin
      clock = 0;
      forever #2 clock = ~clock;
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // A nonzero second address queues one more sector behind the first.
   task automatic run(input fcps_op_e op, input fcps_addr_t a, input fcps_data_t d,
                      input fcps_addr_t a2);
      int k;
      k = 0;
      while (cmd_ready !== 1'b1 && k < 3000) begin
         @(negedge clock);
         k++;
      end
      @(posedge clock);
      cmd_valid <= 1;
      cmd_op <= op;
      cmd_addr <= a;
      cmd_data <= d;
      cmd_more <= (a2 != 0);
      @(posedge clock);
      cmd_addr <= a2;
      // Only one sector follows, so more drops before the first sector's last write.
      cmd_more <= 0;
      if (a2 == 0) cmd_valid <= 0;
      k = 0;
      while (a2 != 0 && flash_u.n_sect < 2 && k < 3000) begin
         @(negedge clock);
         k++;
      end
      @(posedge clock);
      cmd_valid <= 0;
      cmd_more <= 0;
      k = 0;
      while (done_pulse !== 1'b1 && k < 5000) begin
         @(negedge clock);
         k++;
      end
      chk("done_pulse", 1, done_pulse);
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      err_total++;
      tally_and_finish;
   end
   initial begin
      sys_rst = 1;
      cmd_valid = 0;
      cmd_op = FCPS_OP_PROGRAM;
      cmd_addr = 0;
      cmd_data = 0;
      cmd_more = 0;
      fail_mode = 0;
      repeat (16) @(posedge clock);
      sys_rst <= 0;
      @(negedge clock);
      @(negedge clock);
      chk("cmd_ready", 1, cmd_ready);
      chk("idle pins", 5'h1f, {ce_n, oe_n, we_n, rst_n, dq_oe_n});
      $display("test reset done");
      run(FCPS_OP_PROGRAM, 22'h000123, 16'h5a3c, 0);
      chk("prog fail", 0, done_fail);
      chk("prog word", 16'h5a3c, flash_u.mem[8'h23]);
      run(FCPS_OP_PROGRAM, 22'h000124, 16'h00ff, 0);
      chk("prog fail 2", 0, done_fail);
      chk("prog word 2", 16'h00ff, flash_u.mem[8'h24]);
      $display("test program done");
      run(FCPS_OP_SECTOR, 22'h010000, 16'h0000, 22'h020000);
      chk("sectors", 2, flash_u.n_sect);
      chk("erase fail", 0, done_fail);
      chk("erased", 16'hffff, flash_u.mem[8'h23]);
      $display("test sector erase done");
      run(FCPS_OP_PROGRAM, 22'h000011, 16'h1234, 0);
      run(FCPS_OP_CHIP, 22'h000000, 16'h0000, 0);
      chk("chip count", 1, flash_u.n_chip);
      chk("chip fail", 0, done_fail);
      chk("chip erased", 16'hffff, flash_u.mem[8'h11]);
      $display("test chip erase done");
      fail_mode <= 1;
      run(FCPS_OP_PROGRAM, 22'h000030, 16'h0080, 0);
      chk("stuck fail", 1, done_fail);
      fail_mode <= 0;
      run(FCPS_OP_RESET, 22'h000000, 16'h0000, 0);
      chk("reset long", 1, flash_u.rst_len >= `FCPS_RST_PULSE_CYC);
      chk("ready after", 1, rdy);
      run(FCPS_OP_PROGRAM, 22'h000031, 16'h7e81, 0);
      chk("post reset", 0, done_fail);
      chk("post word", 16'h7e81, flash_u.mem[8'h31]);
      $display("test fault and reset done");
      tally_and_finish;
   end
endmodule

// ### hw/fcps_ctrl.sv
// Overview of operation
// [RQ1] Sector erase: five prefix writes, address/30h.
// [RQ2] Chip erase: five prefix writes, 555h/10h.
// [RQ3] Extra sectors queued; device waits 50 us.
// [RQ4] Erase done only when polling reads FFh.
// [RQ5] Program polls bit 7 until true data.
// [RQ6] On timeout flag, re-read poll bit first.
// [RQ7] Per word: program, poll, verify, advance.
// [RQ8] Program is four writes, address and data last.
// [RQ9] Device restores protection after temporary unprotect.
// [RQ10] Device goes busy within 90 ns.
// [RQ11] Device suspends erase within 20 us.
// [RQ12] Reset released 200 ns before first read.
// [RQ13] Device data valid 70 ns after enable.
// [RQ14] Protect: output enable 4 us before strobe.
// [RQ15] Sector erase lasts up to 2.0 s.
// [RQ16] Chip erase final cycle uses word address 555h.
// [RQ17] Toggle bit flips while device is busy.
// [RQ18] Ready returns when the operation ends.
`include "fcps_cfg.svh"

module fcps_ctrl (
   // Clock and reset.
   input  wire logic               clock,
   input  wire logic               sys_rst,
   // User command port.
   input  wire logic               cmd_valid,
   input  wire fcps_pkg::fcps_op_e cmd_op,
   input  wire fcps_pkg::fcps_addr_t cmd_addr,
   input  wire fcps_pkg::fcps_data_t cmd_data,
   input  wire logic               cmd_more,
   output logic                    cmd_ready,
   output logic                    done_pulse,
   output logic                    done_fail,
   // Flash pins.
   output fcps_pkg::fcps_addr_t    flash_addr,
   output logic                    flash_ce_n,
   output logic                    flash_oe_n,
   output logic                    flash_we_n,
   output logic                    flash_reset_n,
   output fcps_pkg::fcps_data_t    flash_dq_out,
   output logic                    flash_dq_oe_n,
   input  wire fcps_pkg::fcps_data_t flash_dq_in,
   input  wire logic               ready_busy_out
);
   import fcps_pkg::*;

   localparam int CNT_W = 24;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.
   fcps_data_t  dq_s1_q;
   fcps_data_t  dq_s2_q;
   logic        rb_s1_q;
   logic        rb_s2_q;
   always_ff @(posedge clock) begin
      dq_s1_q <= flash_dq_in;
      dq_s2_q <= dq_s1_q;
      rb_s1_q <= ready_busy_out;
      rb_s2_q <= rb_s1_q;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer state.
   fcps_state_e      state_q;
   fcps_op_e         op_q;
   fcps_addr_t       addr_q;
   fcps_data_t       data_q;
   logic [2:0]       step_q;
   logic [CNT_W-1:0] cnt_q;
   logic             recheck_q;
   logic             more_q;

   // Command length: program four writes, erases six.
   wire        is_prog  = (op_q == FCPS_OP_PROGRAM);
   wire [2:0]  last_stp = is_prog ? 3'h3 : 3'h5;                     // RQ8
   wire        cnt_zero = (cnt_q == '0);

   // Capture of a queued sector while the current one is being written.
   wire take_more = (state_q == FCPS_WHI) && cnt_zero && (step_q == last_stp) && more_q;
   // A queued sector address goes to the pins in the same edge that starts its write.
   fcps_addr_t tgt_addr;
   logic [2:0] step_d;
   assign tgt_addr = take_more ? cmd_addr : addr_q;

   // Address and data of the write cycle about to run, decoded from the next step.
   // The pins are registered, so decoding the current step would show the previous
   // cycle's address for one clock while the strobe is already low.
   fcps_addr_t wr_addr;
   fcps_data_t wr_data;
   always_comb begin
      wr_addr = `FCPS_ADDR_UNLOCK1;
      wr_data = `FCPS_DATA_UNLOCK1;
      unique case (step_d)
         3'h0: begin
            wr_addr = `FCPS_ADDR_UNLOCK1;
            wr_data = `FCPS_DATA_UNLOCK1;
         end
         3'h1, 3'h4: begin
            wr_addr = `FCPS_ADDR_UNLOCK2;
            wr_data = `FCPS_DATA_UNLOCK2;
         end
         3'h2: begin
            wr_addr = `FCPS_ADDR_UNLOCK1;
            wr_data = is_prog ? `FCPS_DATA_PROGRAM : `FCPS_DATA_ERASE; // RQ1
         end
         3'h3: begin
            wr_addr = is_prog ? tgt_addr : `FCPS_ADDR_UNLOCK1;       // RQ8
            wr_data = is_prog ? data_q : `FCPS_DATA_UNLOCK1;
         end
         3'h5: begin
            wr_addr = (op_q == FCPS_OP_CHIP) ? `FCPS_ADDR_UNLOCK1 : tgt_addr; // RQ16
            wr_data = (op_q == FCPS_OP_CHIP) ? `FCPS_DATA_CHIP          // RQ2
                                             : `FCPS_DATA_SECTOR;      // RQ1
         end
         default: begin
            wr_addr = `FCPS_ADDR_UNLOCK1;
            wr_data = `FCPS_DATA_UNLOCK1;
         end
      endcase
   end

   // Polling evaluation on the synchronised read data.
   wire poll_bit   = dq_s2_q[`FCPS_BIT_POLL];
   wire tout_bit   = dq_s2_q[`FCPS_BIT_TIMEOUT];
   wire prog_match = (poll_bit == data_q[`FCPS_BIT_POLL]);           // RQ5
   wire erase_done = (dq_s2_q[7:0] == `FCPS_DATA_ERASED);            // RQ4
   wire op_done    = is_prog ? prog_match : erase_done;
   wire verify_ok  = is_prog ? (dq_s2_q == data_q) : 1'b1;           // RQ7

   ////////////////////////////////////////////////////////////////////////////
   // Next state.
   fcps_state_e      state_d;
   logic [CNT_W-1:0] cnt_d;
   logic             recheck_d;
   logic             accept;
   always_comb begin
      state_d   = state_q;
      cnt_d     = cnt_zero ? cnt_q : cnt_q - 1'b1;
      step_d    = step_q;
      recheck_d = recheck_q;
      accept    = 1'b0;
      unique case (state_q)
         FCPS_IDLE: if (cmd_valid) begin
            accept    = 1'b1;
            step_d    = 3'h0;
            recheck_d = 1'b0;
            if (cmd_op == FCPS_OP_RESET) begin
               state_d = FCPS_RSTLO;
               cnt_d   = CNT_W'(`FCPS_RST_PULSE_CYC);
            end else begin
               state_d = FCPS_WLO;
               cnt_d   = CNT_W'(`FCPS_WR_PULSE_CYC);
            end
         end
         FCPS_RSTLO: if (cnt_zero) begin
            state_d = FCPS_RSTHI;
            cnt_d   = CNT_W'(`FCPS_RST_HIGH_CYC);                      // RQ12
         end
         FCPS_RSTHI: if (cnt_zero) state_d = FCPS_DONE;
         FCPS_WLO: if (cnt_zero) begin
            state_d = FCPS_WHI;
            cnt_d   = CNT_W'(`FCPS_WR_HIGH_CYC);
         end
         FCPS_WHI: if (cnt_zero) begin
            if (step_q == last_stp && more_q && op_q == FCPS_OP_SECTOR) begin
               // Another sector inside the 50 us window; only its last write repeats.
               state_d = FCPS_WLO;                                   // RQ3
               cnt_d   = CNT_W'(`FCPS_WR_PULSE_CYC);
            end else if (step_q == last_stp) begin
               state_d = FCPS_RLO;
               cnt_d   = CNT_W'(`FCPS_RD_ACCESS_CYC);
            end else begin
               state_d = FCPS_WLO;
               step_d  = step_q + 3'h1;
               cnt_d   = CNT_W'(`FCPS_WR_PULSE_CYC);
            end
         end
         FCPS_RLO: if (cnt_zero) state_d = FCPS_EVAL;
         FCPS_EVAL: begin
            // The read window is still open; the compared data is two synchroniser edges old.
            if (op_done && !recheck_q) begin
               state_d = FCPS_DONE;
            end else if (op_done) begin
               state_d = FCPS_DONE;
            end else if (recheck_q) begin
               state_d = FCPS_DONE;                                  // RQ6
            end else begin
               recheck_d = tout_bit;                                 // RQ6
               state_d   = FCPS_RHI;
               cnt_d     = CNT_W'(`FCPS_RD_HIGH_CYC);
            end
         end
         FCPS_RHI: if (cnt_zero) begin
            state_d = FCPS_RLO;                                      // RQ4
            cnt_d   = CNT_W'(`FCPS_RD_ACCESS_CYC);
         end
         FCPS_DONE: state_d = FCPS_IDLE;
         default:   state_d = FCPS_IDLE;
      endcase
   end

   wire fail_d    = (state_q == FCPS_EVAL) && !op_done && recheck_q;
   wire pass_d    = (state_q == FCPS_EVAL) && op_done;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_q   <= FCPS_IDLE;
         cnt_q     <= '0;
         step_q    <= 3'h0;
         recheck_q <= 1'b0;
         op_q      <= FCPS_OP_PROGRAM;
         addr_q    <= '0;
         data_q    <= '0;
         more_q    <= 1'b0;
      end else begin
         state_q   <= state_d;
         cnt_q     <= cnt_d;
         step_q    <= step_d;
         recheck_q <= recheck_d;
         if (accept) begin
            op_q   <= cmd_op;
            addr_q <= cmd_addr;
            data_q <= cmd_data;
            more_q <= cmd_more;
         end else if (take_more) begin
            addr_q <= cmd_addr;                                      // RQ3
            more_q <= cmd_valid && cmd_more;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered outputs.
   wire in_wr  = (state_d == FCPS_WLO) || (state_d == FCPS_WHI);
   wire in_rd  = (state_d == FCPS_RLO) || (state_d == FCPS_EVAL);
   wire in_rst = (state_d == FCPS_RSTLO);
   wire busy_d = (state_d != FCPS_IDLE);
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         cmd_ready     <= 1'b0;
         done_pulse    <= 1'b0;
         done_fail     <= 1'b0;
         flash_addr    <= '0;
         flash_ce_n    <= 1'b1;
         flash_oe_n    <= 1'b1;
         flash_we_n    <= 1'b1;
         flash_reset_n <= 1'b1;
         flash_dq_out  <= '0;
         flash_dq_oe_n <= 1'b1;
      end else begin
         cmd_ready     <= !busy_d;
         done_pulse    <= (state_d == FCPS_DONE);
         if (pass_d || fail_d) begin
            done_fail  <= fail_d || (pass_d && !verify_ok);          // RQ7
         end
         flash_addr    <= in_rd ? addr_q : wr_addr;
         flash_ce_n    <= !(in_wr || in_rd);
         flash_oe_n    <= !in_rd;
         flash_we_n    <= !(state_d == FCPS_WLO);
         flash_reset_n <= !in_rst;
         flash_dq_out  <= wr_data;
         flash_dq_oe_n <= !in_wr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   // Cycles since the flash reset pin was last released, saturating. It starts
   // saturated because the flash is not held in reset while the controller is.
   logic [7:0] rel_cnt_q;
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rel_cnt_q <= 8'hff;
      end else if (!flash_reset_n) begin
         rel_cnt_q <= 8'h00;
      end else if (rel_cnt_q != 8'hff) begin
         rel_cnt_q <= rel_cnt_q + 8'h01;
      end
   end

   read_after_rst_a: assert property (@(posedge clock) disable iff (sys_rst) // RQ12
      !flash_oe_n |-> rel_cnt_q >= 8'(`FCPS_RST_HIGH_CYC))
      else $error("Read began too soon after reset release.");
   prog_four_wr_a: assert property (@(posedge clock) disable iff (sys_rst) // RQ8
      (state_q == FCPS_WHI && cnt_zero && is_prog) |-> step_q <= 3'h3)
      else $error("Program sequence ran past four writes.");
   chip_addr_a: assert property (@(posedge clock) disable iff (sys_rst) // RQ16
      (!flash_we_n && op_q == FCPS_OP_CHIP && flash_dq_out == `FCPS_DATA_CHIP) |->
      flash_addr == `FCPS_ADDR_UNLOCK1)
      else $error("Chip erase final cycle at wrong address.");
   recheck_fail_a: assert property (@(posedge clock) disable iff (sys_rst) // RQ6
      (state_q == FCPS_EVAL && !op_done && !recheck_q) |=> !done_pulse)
      else $error("Failure declared without re-reading poll bit.");
   erase_ff_a: assert property (@(posedge clock) disable iff (sys_rst) // RQ4
      (state_q == FCPS_EVAL && !is_prog && !erase_done && !recheck_q) |=>
      state_q == FCPS_RHI)
      else $error("Erase judged complete before reading FFh.");
   we_oe_excl_a: assert property (@(posedge clock) disable iff (sys_rst) // RQ14
      !(!flash_we_n && !flash_oe_n))
      else $error("Write strobe and output enable both active.");
   ready_at_done_a: assert property (@(posedge clock) disable iff (sys_rst) // RQ18
      pass_d |-> rb_s2_q)
      else $error("Operation judged done while the device reports busy.");
endmodule
